// file: testbench/ffsdpm_assertions.sv
// Concurrent checks on the APB answer and the spare status pin.
// Assumes it is bound to the top module: one clock, sync active-low reset.
`timescale 1ns/10ps
module ffsdpm_assertions (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic gp_pin_4
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  ready_after_access_a: assert property ($rose(psel && penable) |=> pready)
    else $error("no answer after access");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  ready_needs_access_a: assert property (!(psel && penable) |=> !pready)
    else $error("answer without access");
  err_only_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without answer");
  err_reads_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  // Read data must hold between reads
  rdata_holds_a: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  pin_four_low_a: assert property (!gp_pin_4)
    else $error("unused pin driven high");
  quiet_bus_a: assert property (!psel [*2] |-> !pready && !pslverr)
    else $error("answer on idle bus");
endmodule // ffsdpm_assertions

// file: testbench/ffsdpm_link_model.sv
// Modem side of the bit link: bit clock and received data.
// Assumes the bench calls send; the clock stands still between frames.
`timescale 1ns/10ps
module ffsdpm_link_model (
  output logic link_clk,
  output logic link_data
);
  initial begin
    link_clk = 1'b0;
    link_data = 1'b1;
  end
  // Bits change while the clock is low, MSB first
  task automatic send(input logic [63:0] w, input int n);
    // Keep link edges off the system clock edges
    #10;
    for (int i = n - 1; i >= 0; i--) begin
      link_data = w[i];
      #200 link_clk = 1'b1;
      #200 link_clk = 1'b0;
    end
    // Released line: inverse shown so a stale bit cannot pass
    link_data = ~link_data;
  endtask
endmodule // ffsdpm_link_model

// file: testbench/tb.sv
// Self-checking bench: APB host, link model and read-result queue.
// Assumes package, checker and link model are compiled before this file.
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("mismatch %0t got %h want %h", $time, a, b); end end
bind ffsdpm_top ffsdpm_assertions chk (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .gp_pin_4(gp_pin_4));
module tb;
  import ffsdpm_pkg::*;
  logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, ser_sel_n = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, e;
  logic pready, pslverr, link_clk, link_data;
  logic [5:0] gp;
  ffsdpm_sig_s sig = '0;
  logic [31:0] expq[$];
  logic [7:0] d[67];
  logic [6:0] cfg[3] = '{7'h07, 7'h17, 7'h16};
  int fails = 0, compares = 0, cyc = 0;
  always #25 clk_sys = ~clk_sys;
  ffsdpm_top uut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_clk_in(link_clk), .link_data_in(link_data),
    .ser_sel_n(ser_sel_n), .sig_in(sig), .gp_pin_0(gp[0]), .gp_pin_1(gp[1]),
    .gp_pin_2(gp[2]), .gp_pin_3(gp[3]), .gp_pin_4(gp[4]), .gp_pin_5(gp[5]));
  ffsdpm_link_model lm (.link_clk(link_clk), .link_data(link_data));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    expq.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Read results are judged here, oldest note first
  always @(posedge clk_sys) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      e = expq.pop_front();
      `CHK(prdata, e)
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      test_done;
    end
  end
  initial begin
    void'($urandom(88018));
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    sig <= 10'($urandom);
    @(posedge clk_sys);
    rd(OFS_STATUS, 32'h0);
    rd(8'h24, 32'h0);
    // Top threshold so only the full event can raise the level flag
    wr(OFS_THRESH, 32'h7F);
    for (int i = 0; i < 67; i++) begin
      d[i] = 8'($urandom);
      wr(OFS_FIFO, {24'h0, d[i]});
    end
    rd(OFS_STATUS, 32'h108F);
    rd(OFS_FIFO, {24'h0, d[0]});
    rd(OFS_STATUS, 32'h104D);
    wr(OFS_STATUS, 32'h4);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_THRESH, 32'h0);
    wr(OFS_FIFO, 32'hA5);
    wr(OFS_THRESH, 32'h5);
    rd(OFS_STATUS, 32'h49);
    wr(OFS_OPMODE, 32'h8);
    rd(OFS_STATUS, 32'h49);
    `CHK(gp, 6'b000110)
    // Select low freezes the has-data pin across a draining read
    ser_sel_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(OFS_FIFO, 32'hA5);
    `CHK(gp[2], 1'b1)
    ser_sel_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    `CHK(gp[2], 1'b0)
    wr(OFS_PINMAP_A, 32'h2);
    // Plain, tolerant, then disabled detection of a one-bit-off word
    for (int t = 0; t < 3; t++) begin
      wr(OFS_PATCFG, {25'h0, cfg[t]});
      wr(OFS_OPMODE, 32'hC);
      lm.send(64'h01010100, 32);
      repeat (8) @(posedge clk_sys);
      rd(OFS_STATUS, t == 1 ? 32'h20 : 32'h0);
      `CHK(gp[0], t == 1)
      wr(OFS_OPMODE, 32'h9);
      rd(OFS_STATUS, 32'h0);
    end
    wr(OFS_PINMAP_A, 32'h0);
    wr(OFS_FIFO, 32'h3C);
    wr(OFS_OPMODE, 32'hB);
    lm.send(64'h0, 42);
    repeat (8) @(posedge clk_sys);
    rd(OFS_STATUS, 32'h10);
    `CHK(gp[0], 1'b1)
    wr(OFS_OPMODE, 32'h9);
    rd(OFS_STATUS, 32'h0);
    `CHK(gp[5], sig.clock_output)
    test_done;
  end
endmodule // tb

// file: verilog/ffsdpm_pkg.sv
// Constants, register map and carrier types for the FIFO flag, pattern detect
// and pin mapping block. Assumes a 20 MHz system clock and an APB host.
package ffsdpm_pkg;

  // Storage geometry
  localparam int FIFO_DEPTH = 66;
  localparam logic [6:0] FIFO_LAST = 7'h41;
  localparam logic [6:0] FIFO_FULL_CNT = 7'h42;
  localparam int PAT_BITS = 64;
  localparam logic [6:0] PAT_MAX_SHIFT = 7'h38;

  // Register byte offsets
  localparam logic [7:0] OFS_FIFO = 8'h00;
  localparam logic [7:0] OFS_OPMODE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_THRESH = 8'h0C;
  localparam logic [7:0] OFS_PATCFG = 8'h10;
  localparam logic [7:0] OFS_PATLO = 8'h14;
  localparam logic [7:0] OFS_PATHI = 8'h18;
  localparam logic [7:0] OFS_PINMAP_A = 8'h1C;
  localparam logic [7:0] OFS_PINMAP_B = 8'h20;

  // Field positions
  localparam int OPM_PKT_BIT = 3;
  localparam int OPM_BSYNC_BIT = 4;
  localparam int ST_OVF_BIT = 2;
  localparam int PCFG_EN_BIT = 0;

  // Reset values
  localparam logic [7:0] OPMODE_RST = 8'h09;
  localparam logic [6:0] THRESH_RST = 7'h0F;
  localparam logic [6:0] PATCFG_RST = 7'h07;
  localparam logic [63:0] PATVAL_RST = 64'h0101010101010101;

  // Operating mode codes
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STDBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX = 3'h4;

  // Pin source identifiers
  localparam logic [4:0] S_0 = 5'h00, S_CLK = 5'h01, S_LOCK = 5'h02, S_MRDY = 5'h03;
  localparam logic [4:0] S_AUTO = 5'h04, S_RSSI = 5'h05, S_TOUT = 5'h06, S_RXRDY = 5'h07;
  localparam logic [4:0] S_TXRDY = 5'h08, S_CRC = 5'h09, S_RXDONE = 5'h0A, S_DATA = 5'h0B;
  localparam logic [4:0] S_DCLK = 5'h0C, S_MATCH = 5'h0D, S_FULL = 5'h0E, S_HAS = 5'h0F;
  localparam logic [4:0] S_THR = 5'h10, S_TXDONE = 5'h11;

  typedef enum logic [1:0] {TX_IDLE, TX_PATTERN, TX_DATA, TX_DONE} ffsdpm_tx_e;

  // Status levels produced by neighbouring radio logic on clk_sys
  typedef struct packed {
    logic clock_output;
    logic synth_lock;
    logic mode_switch_done;
    logic auto_sequence_active;
    logic rssi;
    logic timeout;
    logic receive_path_ready;
    logic transmit_path_ready;
    logic checksum_pass;
    logic frame_rx_done;
  } ffsdpm_sig_s;

endpackage

// file: verilog/ffsdpm_top.sv
// FIFO with status flags, mode-change clearing, pattern detector, pattern and
// byte serialiser, and the six-pin status multiplexer, with APB registers.
// Assumes bit clock, bit data and serial select arrive asynchronously.
`timescale 1ns/10ps

module ffsdpm_top
  import ffsdpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk_in,
  input wire logic link_data_in,
  input wire logic ser_sel_n,
  input ffsdpm_sig_s sig_in,
  output logic gp_pin_0,
  output logic gp_pin_1,
  output logic gp_pin_2,
  output logic gp_pin_3,
  output logic gp_pin_4,
  output logic gp_pin_5
);

  function automatic logic [6:0] ptr_inc(input logic [6:0] p);
    ptr_inc = (p == FIFO_LAST) ? 7'h00 : p + 7'h01;
  endfunction

  function automatic logic [6:0] pop_count(input logic [63:0] v);
    logic [6:0] n;
    n = 7'h00;
    for (int i = 0; i < PAT_BITS; i++) begin
      n = n + {6'h00, v[i]};
    end
    pop_count = n;
  endfunction

  function automatic logic clear_on_change(input logic [2:0] old_m, input logic [2:0] new_m);
    clear_on_change = (old_m == MODE_TX && new_m != MODE_TX)
      || (new_m == MODE_RX && old_m != MODE_RX);
  endfunction

  // Source ids for pins {5,4,3,2,1,0} in one mode and code
  function automatic logic [29:0] map_row(input logic pkt, input logic [2:0] m,
                                          input logic [1:0] c);
    logic [29:0] r;
    r = {6{S_0}};
    if (pkt) begin
      unique case ({m, c})
        {MODE_SLEEP, 2'b00}: r = {S_0, S_0, S_FULL, S_HAS, S_THR, S_0};
        {MODE_STDBY, 2'b00}: r = {S_CLK, S_0, S_FULL, S_HAS, S_THR, S_0};
        {MODE_SYNTH, 2'b00}: r = {S_CLK, S_0, S_FULL, S_HAS, S_THR, S_0};
        {MODE_RX, 2'b00}: r = {S_CLK, S_0, S_FULL, S_HAS, S_THR, S_CRC};
        {MODE_TX, 2'b00}: r = {S_CLK, S_0, S_FULL, S_HAS, S_THR, S_TXDONE};
        {MODE_SLEEP, 2'b01}, {MODE_STDBY, 2'b01},
        {MODE_SYNTH, 2'b01}: r = {S_0, S_0, S_0, S_0, S_FULL, S_0};
        {MODE_RX, 2'b01}: r = {S_DATA, S_0, S_RSSI, S_DATA, S_FULL, S_RXDONE};
        {MODE_TX, 2'b01}: r = {S_DATA, S_0, S_TXRDY, S_DATA, S_FULL, S_TXRDY};
        {MODE_SLEEP, 2'b10}, {MODE_STDBY, 2'b10}, {MODE_SYNTH, 2'b10},
        {MODE_TX, 2'b10}: r = {S_0, S_0, S_0, S_0, S_HAS, S_0};
        {MODE_RX, 2'b10}: r = {S_0, S_0, S_MATCH, S_0, S_HAS, S_MATCH};
        {MODE_SLEEP, 2'b11},
        {MODE_STDBY, 2'b11}: r = {S_MRDY, S_0, S_0, S_AUTO, S_0, S_0};
        {MODE_SYNTH, 2'b11},
        {MODE_TX, 2'b11}: r = {S_MRDY, S_0, S_LOCK, S_AUTO, S_LOCK, S_LOCK};
        {MODE_RX, 2'b11}: r = {S_MRDY, S_0, S_LOCK, S_AUTO, S_TOUT, S_RSSI};
        default: r = {6{S_0}};
      endcase
    end else begin
      unique case ({m, c})
        {MODE_SLEEP, 2'b10}, {MODE_STDBY, 2'b10},
        {MODE_SYNTH, 2'b10}: r = {S_0, S_0, S_AUTO, S_0, S_0, S_0};
        {MODE_SLEEP, 2'b11},
        {MODE_STDBY, 2'b11}: r = {S_MRDY, S_0, S_0, S_0, S_0, S_MRDY};
        {MODE_STDBY, 2'b00}: r = {S_CLK, S_0, S_0, S_0, S_0, S_0};
        {MODE_SYNTH, 2'b00}: r = {S_CLK, S_0, S_0, S_0, S_0, S_LOCK};
        {MODE_SYNTH, 2'b11}: r = {S_MRDY, S_0, S_0, S_0, S_LOCK, S_MRDY};
        {MODE_RX, 2'b00}: r = {S_CLK, S_0, S_RSSI, S_DATA, S_DCLK, S_MATCH};
        {MODE_RX, 2'b01}: r = {S_RSSI, S_0, S_RXRDY, S_DATA, S_RXRDY, S_TOUT};
        {MODE_RX, 2'b10}: r = {S_0, S_0, S_AUTO, S_DATA, S_0, S_RSSI};
        {MODE_RX, 2'b11}: r = {S_MRDY, S_0, S_TOUT, S_DATA, S_MATCH, S_MRDY};
        {MODE_TX, 2'b00}: r = {S_CLK, S_0, S_TXRDY, S_DATA, S_DCLK, S_LOCK};
        {MODE_TX, 2'b01}: r = {S_CLK, S_0, S_TXRDY, S_DATA, S_TXRDY, S_TXRDY};
        {MODE_TX, 2'b10}: r = {S_0, S_0, S_AUTO, S_DATA, S_0, S_0};
        {MODE_TX, 2'b11}: r = {S_MRDY, S_0, S_TXRDY, S_DATA, S_LOCK, S_MRDY};
        default: r = {6{S_0}};
      endcase
    end
    map_row = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [6:0] wr_ptr_reg, rd_ptr_reg, cnt_reg, cnt_next;
  logic [7:0] opmode_reg;
  logic [6:0] fifo_threshold_reg;
  logic [6:0] pattern_config_reg;
  logic [63:0] pattern_value;
  logic [7:0] pin_map_reg_a;
  logic [3:0] pin_map_reg_b;
  logic fifo_overflow_flag, fifo_threshold_flag, full_seen_reg, frame_tx_done;
  logic pattern_match_flag, has_data_pin_reg;
  logic clk_s1, clk_s2, clk_s3, dat_s1, dat_s2, sel_s1, sel_s2, sel_s3;
  logic [63:0] hist_reg;
  logic [6:0] seen_reg;
  logic [7:0] rx_sr_reg;
  logic [2:0] rx_bits_reg;
  logic [63:0] tx_pat_reg;
  logic [7:0] tx_sr_reg;
  logic [6:0] tx_left_reg;
  logic tx_bit_reg;
  ffsdpm_tx_e tx_state;
  logic rxrdy_prev, rxdone_prev, rx_win_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic [2:0] mode;
  logic pkt, in_rx, in_tx, has_data, fifo_at_capacity;
  logic wr_fire, rd_fire, host_push, host_pop, sr_push, tx_pop;
  logic push, pop, push_ok, pop_ok, ovf_w1c, mode_clear, fifo_clear;
  logic [7:0] push_data, fifo_head;
  logic bit_rise, bit_fall, sel_fall, detect_on;
  logic [2:0] pat_len, pattern_error_tolerance;
  logic [6:0] pat_shift, pat_nbits;
  logic [63:0] hist_next, pat_mask, pat_expect;
  logic match_now;

  assign mode = opmode_reg[2:0];
  assign pkt = opmode_reg[OPM_PKT_BIT];
  assign in_rx = (mode == MODE_RX);
  assign in_tx = (mode == MODE_TX);
  assign has_data = (cnt_reg != 7'h00);
  assign fifo_at_capacity = (cnt_reg == FIFO_FULL_CNT);
  assign fifo_head = fifo_mem[rd_ptr_reg];
  assign wr_fire = psel && penable && pready && pwrite;
  assign rd_fire = psel && penable && pready && !pwrite;
  // Host and serialiser never share a direction in one mode, so one push max
  assign host_push = wr_fire && (paddr == OFS_FIFO) && !in_rx;
  assign host_pop = rd_fire && (paddr == OFS_FIFO) && !in_tx && has_data;
  assign push = host_push || sr_push;
  assign pop = host_pop || tx_pop;
  assign push_data = host_push ? pwdata[7:0] : {rx_sr_reg[6:0], dat_s2};
  assign push_ok = push && !fifo_at_capacity;
  assign pop_ok = pop && has_data;
  assign ovf_w1c = wr_fire && (paddr == OFS_STATUS) && pwdata[ST_OVF_BIT];
  assign mode_clear = wr_fire && (paddr == OFS_OPMODE)
    && clear_on_change(mode, pwdata[2:0]);
  assign fifo_clear = ovf_w1c || mode_clear;
  assign cnt_next = cnt_reg + {6'h00, push_ok} - {6'h00, pop_ok};

  assign bit_rise = clk_s2 && !clk_s3;
  assign bit_fall = !clk_s2 && clk_s3;
  assign sel_fall = !sel_s2 && sel_s3;
  assign pat_len = pattern_config_reg[3:1];
  assign pattern_error_tolerance = pattern_config_reg[6:4];
  assign pat_nbits = {pat_len, 3'b000} + 7'h08;
  assign pat_shift = PAT_MAX_SHIFT - {1'b0, pat_len, 3'b000};
  assign pat_mask = {PAT_BITS{1'b1}} >> pat_shift;
  assign pat_expect = pattern_value >> pat_shift;
  assign hist_next = {hist_reg[62:0], dat_s2};
  assign detect_on = pattern_config_reg[PCFG_EN_BIT] && in_rx
    && (pkt || opmode_reg[OPM_BSYNC_BIT]);
  assign match_now = detect_on && bit_rise && (seen_reg >= pat_nbits - 7'h01)
    && (pop_count((hist_next ^ pat_expect) & pat_mask)
        <= {4'h0, pattern_error_tolerance});
  assign sr_push = in_rx && pkt && bit_rise && pattern_match_flag
    && (rx_bits_reg == 3'h7);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      {clk_s1, clk_s2, clk_s3} <= 3'b000;
      {dat_s1, dat_s2} <= 2'b00;
      {sel_s1, sel_s2, sel_s3} <= 3'b111;
    end else begin
      {clk_s1, clk_s2, clk_s3} <= {link_clk_in, clk_s1, clk_s2};
      {dat_s1, dat_s2} <= {link_data_in, dat_s1};
      {sel_s1, sel_s2, sel_s3} <= {ser_sel_n, sel_s1, sel_s2};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, then answer
  logic addr_ok;
  logic [31:0] rd_mux;
  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_FIFO: rd_mux = {24'h000000, fifo_head};
      OFS_OPMODE: rd_mux = {24'h000000, opmode_reg};
      OFS_STATUS: rd_mux = {19'h00000, cnt_reg, pattern_match_flag,
        frame_tx_done, fifo_threshold_flag, fifo_overflow_flag,
        fifo_at_capacity, has_data};
      OFS_THRESH: rd_mux = {25'h0000000, fifo_threshold_reg};
      OFS_PATCFG: rd_mux = {25'h0000000, pattern_config_reg};
      OFS_PATLO: rd_mux = pattern_value[31:0];
      OFS_PATHI: rd_mux = pattern_value[63:32];
      OFS_PINMAP_A: rd_mux = {24'h000000, pin_map_reg_a};
      OFS_PINMAP_B: rd_mux = {28'h0000000, pin_map_reg_b};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= addr_ok ? rd_mux : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      opmode_reg <= OPMODE_RST;
      fifo_threshold_reg <= THRESH_RST;
      pattern_config_reg <= PATCFG_RST;
      pattern_value <= PATVAL_RST;
      pin_map_reg_a <= 8'h00;
      pin_map_reg_b <= 4'h0;
    end else if (wr_fire) begin
      unique case (paddr)
        OFS_OPMODE: opmode_reg <= pwdata[7:0];
        OFS_THRESH: fifo_threshold_reg <= pwdata[6:0];
        OFS_PATCFG: pattern_config_reg <= pwdata[6:0];
        OFS_PATLO: pattern_value[31:0] <= pwdata;
        OFS_PATHI: pattern_value[63:32] <= pwdata;
        OFS_PINMAP_A: pin_map_reg_a <= pwdata[7:0];
        OFS_PINMAP_B: pin_map_reg_b <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO storage and pointers
  always_ff @(posedge clk_sys) begin
    if (push_ok && !fifo_clear) begin
      fifo_mem[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst || fifo_clear) begin
      wr_ptr_reg <= 7'h00;
      rd_ptr_reg <= 7'h00;
      cnt_reg <= 7'h00;
    end else begin
      if (push_ok) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop_ok) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      cnt_reg <= cnt_next;
    end
  end

  // Overflow: a new overrun in the clearing cycle keeps the flag set
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fifo_overflow_flag <= 1'b0;
    end else if (push && fifo_at_capacity) begin
      fifo_overflow_flag <= 1'b1;
    end else if (ovf_w1c) begin
      fifo_overflow_flag <= 1'b0;
    end
  end

  // Threshold: ignores threshold edits, frozen high from full until empty
  always_ff @(posedge clk_sys) begin
    if (!nrst || fifo_clear) begin
      fifo_threshold_flag <= 1'b0;
      full_seen_reg <= 1'b0;
    end else if (push_ok || pop_ok) begin
      if (cnt_next == FIFO_FULL_CNT) begin
        full_seen_reg <= 1'b1;
        fifo_threshold_flag <= 1'b1;
      end else if (cnt_next == 7'h00) begin
        full_seen_reg <= 1'b0;
        fifo_threshold_flag <= 1'b0;
      end else if (!full_seen_reg) begin
        fifo_threshold_flag <= (cnt_next > fifo_threshold_reg);
      end
    end
  end

  // Pin copy of has-data: frozen during a select-low frame
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      has_data_pin_reg <= 1'b0;
    end else if (sel_s2 || sel_fall) begin
      has_data_pin_reg <= has_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern detector and receive byte assembly
  always_ff @(posedge clk_sys) begin
    if (!nrst || !in_rx) begin
      hist_reg <= 64'h0000_0000_0000_0000;
      seen_reg <= 7'h00;
    end else if (bit_rise) begin
      hist_reg <= hist_next;
      seen_reg <= (seen_reg == PAT_MAX_SHIFT + 7'h08) ? seen_reg : seen_reg + 7'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pattern_match_flag <= 1'b0;
    end else if (match_now) begin
      pattern_match_flag <= 1'b1;
    end else if (!in_rx || fifo_clear || (has_data && cnt_next == 7'h00)) begin
      pattern_match_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst || !in_rx || !pattern_match_flag) begin
      rx_sr_reg <= 8'h00;
      rx_bits_reg <= 3'h0;
    end else if (bit_rise) begin
      rx_sr_reg <= {rx_sr_reg[6:0], dat_s2};
      rx_bits_reg <= rx_bits_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit serialiser: pattern first, then FIFO bytes, MSB first
  always_comb begin
    tx_pop = in_tx && bit_fall && (tx_state == TX_DATA)
      && (tx_left_reg == 7'h00) && has_data;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst || !in_tx || !pkt) begin
      tx_state <= TX_IDLE;
      tx_pat_reg <= 64'h0000_0000_0000_0000;
      tx_sr_reg <= 8'h00;
      tx_left_reg <= 7'h00;
      tx_bit_reg <= 1'b0;
      frame_tx_done <= 1'b0;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          if (has_data) begin
            tx_state <= TX_PATTERN;
            tx_pat_reg <= pattern_value << pat_shift;
            tx_left_reg <= pat_nbits;
          end
        end
        TX_PATTERN: begin
          if (bit_fall) begin
            tx_bit_reg <= tx_pat_reg[63];
            tx_pat_reg <= {tx_pat_reg[62:0], 1'b0};
            tx_left_reg <= tx_left_reg - 7'h01;
            if (tx_left_reg == 7'h01) begin
              tx_state <= TX_DATA;
            end
          end
        end
        TX_DATA: begin
          if (bit_fall) begin
            if (tx_left_reg != 7'h00) begin
              tx_bit_reg <= tx_sr_reg[7];
              tx_sr_reg <= {tx_sr_reg[6:0], 1'b0};
              tx_left_reg <= tx_left_reg - 7'h01;
            end else if (has_data) begin
              tx_bit_reg <= fifo_head[7];
              tx_sr_reg <= {fifo_head[6:0], 1'b0};
              tx_left_reg <= 7'h07;
            end else begin
              tx_state <= TX_DONE;
              frame_tx_done <= 1'b1;
            end
          end
        end
        TX_DONE: frame_tx_done <= 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin multiplexer
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rxrdy_prev <= 1'b0;
      rxdone_prev <= 1'b0;
      rx_win_reg <= 1'b0;
    end else begin
      rxrdy_prev <= sig_in.receive_path_ready;
      rxdone_prev <= sig_in.frame_rx_done;
      if (!in_rx || (sig_in.frame_rx_done && !rxdone_prev)) begin
        rx_win_reg <= 1'b0;
      end else if (sig_in.receive_path_ready && !rxrdy_prev) begin
        rx_win_reg <= 1'b1;
      end
    end
  end

  logic [31:0] src;
  logic [5:0] pin_next;
  logic [11:0] codes;
  logic [29:0] row;
  logic data_bit;
  always_comb begin
    data_bit = in_tx ? tx_bit_reg : (dat_s2 && (!pkt || rx_win_reg));
    src = 32'h0000_0000;
    src[S_CLK] = sig_in.clock_output;
    src[S_LOCK] = sig_in.synth_lock;
    src[S_MRDY] = sig_in.mode_switch_done;
    src[S_AUTO] = sig_in.auto_sequence_active;
    src[S_RSSI] = sig_in.rssi;
    src[S_TOUT] = sig_in.timeout;
    src[S_RXRDY] = sig_in.receive_path_ready;
    src[S_TXRDY] = sig_in.transmit_path_ready;
    src[S_CRC] = sig_in.checksum_pass;
    src[S_RXDONE] = sig_in.frame_rx_done;
    src[S_DATA] = data_bit;
    src[S_DCLK] = clk_s2 && opmode_reg[OPM_BSYNC_BIT];
    src[S_MATCH] = pattern_match_flag;
    src[S_FULL] = fifo_at_capacity;
    src[S_HAS] = has_data_pin_reg;
    src[S_THR] = fifo_threshold_flag;
    src[S_TXDONE] = frame_tx_done;
    codes = {pin_map_reg_b, pin_map_reg_a};
    pin_next = 6'h00;
    row = 30'h0000_0000;
    for (int p = 0; p < 6; p++) begin
      row = map_row(pkt, mode, codes[2*p +: 2]);
      pin_next[p] = src[row[5*p +: 5]];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      {gp_pin_5, gp_pin_4, gp_pin_3, gp_pin_2, gp_pin_1, gp_pin_0} <= 6'h00;
    end else begin
      {gp_pin_5, gp_pin_4, gp_pin_3, gp_pin_2, gp_pin_1, gp_pin_0} <= pin_next;
    end
  end

endmodule // ffsdpm_top
